//--- rtl/drive_control_status_params.sv
// control and status parameter set of the motor drive, fieldbus side
// assumes the drive core shares SYS_CLK_IN and answers state changes itself
`timescale 1ns/1ps
`include "drive_params_defines.svh"

module drive_control_status_params #(
  parameter bit CANOPEN_VARIANT = 1'b1
) (
  // clock, reset, enable
  input wire logic SYS_CLK_IN,
  input wire logic SYS_RST_IN,
  input wire logic CE_IN,
  // fieldbus parameter access
  input wire logic [15:0] PAR_ADDR_IN,
  input wire logic PAR_WR_IN,
  input wire logic PAR_RD_IN,
  input wire logic [15:0] PAR_WDATA_IN,
  output logic [15:0] PAR_RDATA_OUT,
  output logic PAR_ACK_OUT,
  output logic PAR_ERR_OUT,
  // drive core state
  input wire logic [3:0] DRIVE_STATE_IN,
  input wire drive_params_pkg::status_in_t STATUS_IN,
  input wire logic ETH_DATA_ERR_IN,
  // decoded commands to the drive core
  output drive_params_pkg::ctrl_decode_t CTRL_OUT,
  output drive_params_pkg::op_mode_t MODE_OUT,
  output logic ADVANCE_REQ_OUT,
  output logic ETH_WARN_OUT,
  output logic QUICK_STOP_REQ_OUT
);
  import drive_params_pkg::*;

  function automatic op_mode_t mode_decode(input logic [15:0] code);
    case (code)
      `OPMODE_PROFILE_POS: mode_decode = MODE_PROFILE_POS;
      `OPMODE_PROFILE_VEL: mode_decode = MODE_PROFILE_VEL;
      `OPMODE_HOMING: mode_decode = MODE_HOMING;
      `OPMODE_JOG: mode_decode = MODE_JOG;
      default: mode_decode = MODE_NONE;
    endcase
  endfunction

  // register group
  logic [15:0] eth_class_reg, eth_class_next;
  logic [15:0] ctrl_reg, ctrl_next;
  logic [15:0] opmode_reg, opmode_next;
  logic [15:0] trans_reg, trans_next;
  logic [15:0] status_reg, status_next;
  logic [15:0] rdata_reg, rdata_next;
  logic ack_reg, ack_next;
  logic err_reg, err_next;
  logic ctrl_wr_reg, ctrl_wr_next;
  logic eth_warn_sticky_reg, eth_warn_sticky_next;
  logic hit;
  logic writable;

  // bus access and status capture
  always_comb begin
    eth_class_next = eth_class_reg;
    ctrl_next = ctrl_reg;
    opmode_next = opmode_reg;
    trans_next = trans_reg;
    rdata_next = rdata_reg;
    ack_next = 1'b0;
    err_next = 1'b0;
    ctrl_wr_next = 1'b0;
    hit = 1'b1;
    writable = 1'b1;
    case (PAR_ADDR_IN)
      `ADDR_ETH_ERR_CLASS: rdata_next = eth_class_reg;
      `ADDR_CTRL_WORD: rdata_next = ctrl_reg;
      `ADDR_STATUS_WORD: begin
        rdata_next = status_reg;
        writable = 1'b0;
      end
      `ADDR_OPMODE: rdata_next = opmode_reg;
      `ADDR_TRANSITION: rdata_next = trans_reg;
      default: begin
        rdata_next = 16'h0000;
        hit = 1'b0;
        writable = 1'b0;
      end
    endcase
    if (PAR_RD_IN || PAR_WR_IN) begin
      ack_next = 1'b1;
      err_next = !hit || (PAR_WR_IN && !writable);
    end
    if (!PAR_RD_IN) begin
      rdata_next = rdata_reg;
    end
    if (PAR_WR_IN && writable) begin
      case (PAR_ADDR_IN)
        `ADDR_ETH_ERR_CLASS: eth_class_next = PAR_WDATA_IN;
        `ADDR_CTRL_WORD: begin
          ctrl_next = PAR_WDATA_IN;
          ctrl_wr_next = 1'b1;
        end
        `ADDR_OPMODE: opmode_next = PAR_WDATA_IN;
        `ADDR_TRANSITION: trans_next = PAR_WDATA_IN;
        default: ctrl_wr_next = 1'b0;
      endcase
    end
    // eth warning stays up until a fault reset; a new error wins
    eth_warn_sticky_next = eth_warn_sticky_reg;
    if (ctrl_wr_next && PAR_WDATA_IN[`CW_FAULT_RESET]) begin
      eth_warn_sticky_next = 1'b0;
    end
    if (ETH_DATA_ERR_IN && eth_class_reg == `ETH_CLASS_WARNING) begin
      eth_warn_sticky_next = 1'b1;
    end
    status_next = 16'h0000;
    status_next[3:0] = STATUS_IN.sm_bits[3:0];
    status_next[6:5] = STATUS_IN.sm_bits[5:4];
    status_next[`SW_VOLTAGE_ENABLED] = STATUS_IN.voltage_enabled;
    status_next[`SW_WARNING] = STATUS_IN.warning || eth_warn_sticky_reg;
    status_next[`SW_TARGET_REACHED] = STATUS_IN.target_reached;
    status_next[`SW_HALT_ACTIVE] = ctrl_reg[`CW_HALT];
    status_next[`SW_REMOTE] = STATUS_IN.remote;
    status_next[`SW_MODE_SPECIFIC] = STATUS_IN.mode_specific;
    status_next[`SW_MOTION_ERROR] = STATUS_IN.motion_error;
    status_next[`SW_MOTION_FINISHED] = STATUS_IN.motion_finished;
    status_next[`SW_HOMING_VALID] = STATUS_IN.homing_valid;
  end

  always_ff @(posedge SYS_CLK_IN or posedge SYS_RST_IN) begin
    if (SYS_RST_IN) begin
      eth_class_reg <= `RST_ETH_ERR_CLASS;
      ctrl_reg <= `RST_CTRL_WORD;
      opmode_reg <= `RST_OPMODE;
      trans_reg <= `RST_TRANSITION;
      status_reg <= 16'h0000;
      rdata_reg <= 16'h0000;
      ack_reg <= 1'b0;
      err_reg <= 1'b0;
      ctrl_wr_reg <= 1'b0;
      eth_warn_sticky_reg <= 1'b0;
    end else if (CE_IN) begin
      eth_class_reg <= eth_class_next;
      ctrl_reg <= ctrl_next;
      opmode_reg <= opmode_next;
      trans_reg <= trans_next;
      status_reg <= status_next;
      rdata_reg <= rdata_next;
      ack_reg <= ack_next;
      err_reg <= err_next;
      ctrl_wr_reg <= ctrl_wr_next;
      eth_warn_sticky_reg <= eth_warn_sticky_next;
    end
  end

  // decoded command group
  ctrl_decode_t ctrl_dec_reg, ctrl_dec_next;
  op_mode_t mode_reg, mode_next;
  logic warn_reg, warn_next;
  logic qstop_reg, qstop_next;

  always_comb begin
    ctrl_dec_next.switch_on = ctrl_reg[`CW_SWITCH_ON];
    ctrl_dec_next.enable_voltage = ctrl_reg[`CW_ENABLE_VOLTAGE];
    ctrl_dec_next.quick_stop = ctrl_reg[`CW_QUICK_STOP];
    ctrl_dec_next.enable_operation = ctrl_reg[`CW_ENABLE_OPERATION];
    ctrl_dec_next.mode_bits = ctrl_reg[`CW_MODE_MSB:`CW_MODE_LSB];
    ctrl_dec_next.fault_reset = ctrl_reg[`CW_FAULT_RESET];
    ctrl_dec_next.halt = ctrl_reg[`CW_HALT];
    mode_next = mode_decode(opmode_reg);
    warn_next = ETH_DATA_ERR_IN && eth_class_reg == `ETH_CLASS_WARNING;
    qstop_next = ETH_DATA_ERR_IN && eth_class_reg == `ETH_CLASS_QUICK_STOP;
  end

  always_ff @(posedge SYS_CLK_IN or posedge SYS_RST_IN) begin
    if (SYS_RST_IN) begin
      ctrl_dec_reg <= '0;
      mode_reg <= MODE_NONE;
      warn_reg <= 1'b0;
      qstop_reg <= 1'b0;
    end else if (CE_IN) begin
      ctrl_dec_reg <= ctrl_dec_next;
      mode_reg <= mode_next;
      warn_reg <= warn_next;
      qstop_reg <= qstop_next;
    end
  end

  // switch-on-disabled to ready-to-switch-on advance
  adv_state_t adv_reg, adv_next;
  logic auto_mode;
  logic shutdown_cmd;
  logic in_disabled;

  always_comb begin
    auto_mode = !CANOPEN_VARIANT || trans_reg == `TRANSITION_AUTOMATIC;
    shutdown_cmd = ctrl_wr_reg &&
      ((ctrl_reg & `CMD_SHUTDOWN_MASK) == `CMD_SHUTDOWN_VALUE);
    in_disabled = DRIVE_STATE_IN == `STATE_SWITCH_ON_DISABLED;
    adv_next = adv_reg;
    case (adv_reg)
      ADV_IDLE: begin
        if (in_disabled && (auto_mode || shutdown_cmd)) begin
          adv_next = ADV_REQ;
        end
      end
      ADV_REQ: adv_next = ADV_WAIT;
      ADV_WAIT: begin
        if (!in_disabled) begin
          adv_next = ADV_IDLE;
        end
      end
      default: adv_next = ADV_IDLE;
    endcase
  end

  always_ff @(posedge SYS_CLK_IN or posedge SYS_RST_IN) begin
    if (SYS_RST_IN) begin
      adv_reg <= ADV_IDLE;
    end else if (CE_IN) begin
      adv_reg <= adv_next;
    end
  end

  assign PAR_RDATA_OUT = rdata_reg;
  assign PAR_ACK_OUT = ack_reg;
  assign PAR_ERR_OUT = err_reg;
  assign CTRL_OUT = ctrl_dec_reg;
  assign MODE_OUT = mode_reg;
  assign ADVANCE_REQ_OUT = (adv_reg == ADV_REQ);
  assign ETH_WARN_OUT = warn_reg;
  assign QUICK_STOP_REQ_OUT = qstop_reg;

endmodule

//--- rtl/drive_params_defines.svh
// offsets, field positions, reset values and codes of the drive parameter set
// assumes inclusion by bare name from the top module and the bench files
`ifndef DRIVE_PARAMS_DEFINES_SVH
`define DRIVE_PARAMS_DEFINES_SVH

// parameter addresses as seen by the fieldbus
`define ADDR_ETH_ERR_CLASS 16'h190C
`define ADDR_CTRL_WORD 16'h1B02
`define ADDR_STATUS_WORD 16'h1B04
`define ADDR_OPMODE 16'h1B06
`define ADDR_TRANSITION 16'h1B26

// reset values
`define RST_ETH_ERR_CLASS 16'h0000
`define RST_CTRL_WORD 16'h0000
`define RST_OPMODE 16'h0000
`define RST_TRANSITION 16'h0000

// control word fields
`define CW_SWITCH_ON 0
`define CW_ENABLE_VOLTAGE 1
`define CW_QUICK_STOP 2
`define CW_ENABLE_OPERATION 3
`define CW_MODE_LSB 4
`define CW_MODE_MSB 6
`define CW_FAULT_RESET 7
`define CW_HALT 8

// status word fields
`define SW_VOLTAGE_ENABLED 4
`define SW_WARNING 7
`define SW_HALT_ACTIVE 8
`define SW_REMOTE 9
`define SW_TARGET_REACHED 10
`define SW_MODE_SPECIFIC 12
`define SW_MOTION_ERROR 13
`define SW_MOTION_FINISHED 14
`define SW_HOMING_VALID 15

// operating mode codes, signed 16-bit
`define OPMODE_PROFILE_POS 16'h0001
`define OPMODE_PROFILE_VEL 16'h0003
`define OPMODE_HOMING 16'h0006
`define OPMODE_JOG 16'hFFFF

// state numbers and the shutdown command pattern on bits 2..0
`define STATE_SWITCH_ON_DISABLED 4'h3
`define CMD_SHUTDOWN_MASK 16'h0007
`define CMD_SHUTDOWN_VALUE 16'h0006

// setting values
`define TRANSITION_AUTOMATIC 16'h0000
`define ETH_CLASS_WARNING 16'h0000
`define ETH_CLASS_QUICK_STOP 16'h0001

`endif

//--- rtl/drive_params_pkg.sv
// types shared by the drive parameter set and its surroundings
// needs nothing from the defines header
package drive_params_pkg;

  typedef enum logic [2:0] {
    MODE_NONE = 3'b000,
    MODE_PROFILE_POS = 3'b001,
    MODE_PROFILE_VEL = 3'b010,
    MODE_HOMING = 3'b011,
    MODE_JOG = 3'b100
  } op_mode_t;

  typedef enum logic [1:0] {
    ADV_IDLE = 2'b00,
    ADV_REQ = 2'b01,
    ADV_WAIT = 2'b10
  } adv_state_t;

  typedef struct packed {
    logic switch_on;
    logic enable_voltage;
    logic quick_stop;
    logic enable_operation;
    logic [2:0] mode_bits;
    logic fault_reset;
    logic halt;
  } ctrl_decode_t;

  typedef struct packed {
    logic [5:0] sm_bits;
    logic voltage_enabled;
    logic warning;
    logic remote;
    logic target_reached;
    logic mode_specific;
    logic motion_error;
    logic motion_finished;
    logic homing_valid;
  } status_in_t;

endpackage

//--- tb/drive_params_chk.sv
// port assertions of the drive parameter set
// assumes the bench holds CE_IN high
`timescale 1ns/1ps
`include "drive_params_defines.svh"
module drive_params_chk (
  // clock, reset, enable
  input wire logic SYS_CLK_IN,
  input wire logic SYS_RST_IN,
  input wire logic CE_IN,
  // fieldbus parameter access
  input wire logic PAR_WR_IN,
  input wire logic PAR_RD_IN,
  input wire logic [15:0] PAR_ADDR_IN,
  input wire logic [15:0] PAR_WDATA_IN,
  input wire logic [15:0] PAR_RDATA_OUT,
  input wire logic PAR_ACK_OUT,
  input wire logic PAR_ERR_OUT,
  // drive core side
  input wire logic ETH_DATA_ERR_IN,
  input wire logic [3:0] DRIVE_STATE_IN,
  input wire drive_params_pkg::status_in_t STATUS_IN,
  // decoded outputs
  input wire logic ADVANCE_REQ_OUT,
  input wire logic ETH_WARN_OUT,
  input wire logic QUICK_STOP_REQ_OUT,
  input wire drive_params_pkg::ctrl_decode_t CTRL_OUT,
  input wire drive_params_pkg::op_mode_t MODE_OUT
);
  import drive_params_pkg::*;
  default clocking cb @(posedge SYS_CLK_IN); endclocking
  default disable iff (SYS_RST_IN);
  sequence s_rs;
    PAR_RD_IN && PAR_ADDR_IN == `ADDR_STATUS_WORD && $stable(STATUS_IN) && !$past(SYS_RST_IN);
  endsequence
  property p_adv; ADVANCE_REQ_OUT |-> $past(DRIVE_STATE_IN) == 4'h3 ##1 !ADVANCE_REQ_OUT; endproperty
  a_adv: assert property (p_adv) else $error("advance");
  property p_ctrl; PAR_WR_IN && PAR_ADDR_IN == `ADDR_CTRL_WORD |-> ##2
    CTRL_OUT.halt == $past(PAR_WDATA_IN[8], 2) && CTRL_OUT.switch_on == $past(PAR_WDATA_IN[0], 2);
  endproperty
  a_ctrl: assert property (p_ctrl) else $error("control decode");
  property p_mode; PAR_WR_IN && PAR_ADDR_IN == `ADDR_OPMODE && PAR_WDATA_IN == `OPMODE_JOG
    |-> ##2 MODE_OUT == MODE_JOG; endproperty
  a_mode: assert property (p_mode) else $error("mode");
  property p_swlo; s_rs |=> PAR_RDATA_OUT[3:0] == $past(STATUS_IN.sm_bits[3:0])
    && PAR_RDATA_OUT[4] == $past(STATUS_IN.voltage_enabled)
    && PAR_RDATA_OUT[10] == $past(STATUS_IN.target_reached); endproperty
  a_swlo: assert property (p_swlo) else $error("status low");
  property p_swmid; s_rs |=> !PAR_RDATA_OUT[11] && PAR_RDATA_OUT[9] == $past(STATUS_IN.remote);
  endproperty
  a_swmid: assert property (p_swmid) else $error("status mid");
  property p_swhi; s_rs |=> PAR_RDATA_OUT[15] == $past(STATUS_IN.homing_valid)
    && PAR_RDATA_OUT[13] == $past(STATUS_IN.motion_error); endproperty
  a_swhi: assert property (p_swhi) else $error("status high");
  property p_eth; ETH_WARN_OUT || QUICK_STOP_REQ_OUT |->
    $past(ETH_DATA_ERR_IN) && !(ETH_WARN_OUT && QUICK_STOP_REQ_OUT); endproperty
  a_eth: assert property (p_eth) else $error("eth error");
  property p_ro; CE_IN && PAR_WR_IN && PAR_ADDR_IN == `ADDR_STATUS_WORD
    |=> PAR_ACK_OUT && PAR_ERR_OUT; endproperty
  a_ro: assert property (p_ro) else $error("status write");
  c_adv: cover property (ADVANCE_REQ_OUT);
  c_qs: cover property (QUICK_STOP_REQ_OUT);
  c_err: cover property (PAR_ERR_OUT);
endmodule
bind drive_control_status_params drive_params_chk i_drive_params_chk (.*);

//--- tb/fieldbus_master.sv
// fieldbus master model issuing single parameter accesses
// assumes calls start at a falling clock edge
`timescale 1ns/1ps
`include "drive_params_defines.svh"
module fieldbus_master (
  // clock and answer
  input wire logic clk_in,
  input wire logic ack_in,
  input wire logic err_in,
  input wire logic [15:0] rdata_in,
  // request
  output logic wr_out,
  output logic rd_out,
  output logic [15:0] addr_out,
  output logic [15:0] wdata_out
);
  logic timed_out;
  initial begin
    {wr_out, rd_out, timed_out} = '0;
    addr_out = '0;
    wdata_out = '0;
  end
  task automatic access(input logic w, input logic [15:0] a, d,
      output logic [15:0] r, output logic e);
    int n;
    if (a == `ADDR_CTRL_WORD) d[15:9] = '0;
    addr_out = a;
    wdata_out = d;
    wr_out = w;
    rd_out = !w;
    @(negedge clk_in);
    wr_out = 1'b0;
    rd_out = 1'b0;
    wdata_out = ~d;
    n = 0;
    while (ack_in !== 1'b1 && n < 4) begin
      @(negedge clk_in);
      n++;
    end
    timed_out = ack_in !== 1'b1;
    r = rdata_in;
    e = err_in;
  endtask
endmodule

//--- tb/drive_control_status_params_bench.sv
// self-checking bench of the drive parameter set
// assumes master model and checker compiled first
`timescale 1ns/1ps
`include "drive_params_defines.svh"
module drive_control_status_params_bench;
  import drive_params_pkg::*;
  logic clk, rst, eth_err, ack, err, wr, rd, adv, warn, qs, adv_nc;
  logic [3:0] state;
  logic [15:0] addr, wdata, rdata;
  status_in_t sts;
  ctrl_decode_t ctrl;
  op_mode_t mode;
  int mismatches, checks_done, adv_cnt, nc_cnt;
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  fieldbus_master i_fieldbus_master (.clk_in(clk), .ack_in(ack), .err_in(err),
    .rdata_in(rdata), .wr_out(wr), .rd_out(rd), .addr_out(addr), .wdata_out(wdata));
  drive_control_status_params #(.CANOPEN_VARIANT(1'b1)) i_drive_control_status_params (
    .SYS_CLK_IN(clk), .SYS_RST_IN(rst), .CE_IN(1'b1), .PAR_ADDR_IN(addr), .PAR_WR_IN(wr),
    .PAR_RD_IN(rd), .PAR_WDATA_IN(wdata), .PAR_RDATA_OUT(rdata), .PAR_ACK_OUT(ack),
    .PAR_ERR_OUT(err), .DRIVE_STATE_IN(state), .STATUS_IN(sts), .ETH_DATA_ERR_IN(eth_err),
    .CTRL_OUT(ctrl), .MODE_OUT(mode), .ADVANCE_REQ_OUT(adv), .ETH_WARN_OUT(warn),
    .QUICK_STOP_REQ_OUT(qs));
  always @(posedge clk) if (adv === 1'b1) adv_cnt++;
  // variant without the setting: advance must stay automatic
  drive_control_status_params #(.CANOPEN_VARIANT(1'b0)) i_drive_control_status_params_nc (
    .SYS_CLK_IN(clk), .SYS_RST_IN(rst), .CE_IN(1'b1), .PAR_ADDR_IN(addr), .PAR_WR_IN(wr),
    .PAR_RD_IN(rd), .PAR_WDATA_IN(wdata), .PAR_RDATA_OUT(), .PAR_ACK_OUT(),
    .PAR_ERR_OUT(), .DRIVE_STATE_IN(state), .STATUS_IN(sts), .ETH_DATA_ERR_IN(eth_err),
    .CTRL_OUT(), .MODE_OUT(), .ADVANCE_REQ_OUT(adv_nc), .ETH_WARN_OUT(),
    .QUICK_STOP_REQ_OUT());
  always @(posedge clk) if (adv_nc === 1'b1) nc_cnt++;
  task automatic results();
    if (mismatches == 0 && checks_done > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic check(input logic [15:0] seen, exp);
    checks_done++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic acc(input logic w, input logic [15:0] a, d, output logic [15:0] r,
      output logic e);
    i_fieldbus_master.access(w, a, d, r, e);
    if (i_fieldbus_master.timed_out) begin
      mismatches++;
      results();
    end
  endtask
  function automatic logic [15:0] sw_exp(input status_in_t s);
    return {s.homing_valid, s.motion_finished, s.motion_error, s.mode_specific, 1'b0,
      s.target_reached, s.remote, 1'b1, s.warning, s.sm_bits[5:4], s.voltage_enabled,
      s.sm_bits[3:0]};
  endfunction
  task automatic t_ctrl_modes();
    logic [15:0] r;
    logic e;
    logic [15:0] codes [5] = '{`OPMODE_PROFILE_POS, `OPMODE_PROFILE_VEL, `OPMODE_HOMING,
      `OPMODE_JOG, 16'h0002};
    op_mode_t exp [5] = '{MODE_PROFILE_POS, MODE_PROFILE_VEL, MODE_HOMING, MODE_JOG, MODE_NONE};
    acc(1'b1, `ADDR_CTRL_WORD, 16'hFF95, r, e);
    @(negedge clk);
    check(16'(ctrl), 16'h0147);
    acc(1'b0, `ADDR_CTRL_WORD, 16'h0, r, e);
    check(r, 16'h0195);
    for (int i = 0; i < 5; i++) begin
      acc(1'b1, `ADDR_OPMODE, codes[i], r, e);
      @(negedge clk);
      check(16'(mode), 16'(exp[i]));
    end
  endtask
  task automatic t_status();
    logic [15:0] r;
    logic e;
    for (int i = 0; i < 2; i++) begin
      sts = i ? 14'h152A : 14'h2AD5;
      repeat (3) @(negedge clk);
      acc(1'b0, `ADDR_STATUS_WORD, 16'h0, r, e);
      check(r, sw_exp(sts));
      acc(1'b1, `ADDR_STATUS_WORD, ~r, r, e);
      check(16'(e), 16'h1);
      acc(1'b0, `ADDR_STATUS_WORD, 16'h0, r, e);
      check(r, sw_exp(sts));
    end
    acc(1'b0, 16'h1B00, 16'h0, r, e);
    check({r[14:0], e}, 16'h0001);
  endtask
  task automatic t_eth();
    logic [15:0] r;
    logic e;
    sts = '0;
    for (int i = 0; i < 2; i++) begin
      acc(1'b1, `ADDR_ETH_ERR_CLASS, 16'(i), r, e);
      eth_err = 1'b1;
      @(negedge clk);
      check(16'({warn, qs}), i ? 16'h1 : 16'h2);
      eth_err = 1'b0;
      @(negedge clk);
    end
    repeat (2) @(negedge clk);
    acc(1'b0, `ADDR_STATUS_WORD, 16'h0, r, e);
    check(16'(r[7]), 16'h1);
  endtask
  task automatic t_adv();
    logic [15:0] r;
    logic e;
    state = `STATE_SWITCH_ON_DISABLED;
    adv_cnt = 0;
    repeat (8) @(negedge clk);
    check(16'(adv_cnt), 16'h1);
    state = 4'h4;
    acc(1'b1, `ADDR_TRANSITION, 16'h0001, r, e);
    state = `STATE_SWITCH_ON_DISABLED;
    adv_cnt = 0;
    nc_cnt = 0;
    repeat (8) @(negedge clk);
    check(16'(adv_cnt), 16'h0);
    check(16'(nc_cnt), 16'h1);
    acc(1'b1, `ADDR_CTRL_WORD, `CMD_SHUTDOWN_VALUE, r, e);
    repeat (3) @(negedge clk);
    check(16'(adv_cnt), 16'h1);
    state = 4'h0;
  endtask
  initial begin
    {rst, eth_err, mismatches, checks_done, adv_cnt, nc_cnt} = '0;
    rst = 1'b1;
    state = 4'h0;
    sts = '0;
    repeat (5) @(negedge clk);
    rst = 1'b0;
    t_ctrl_modes();
    t_status();
    t_eth();
    t_adv();
    results();
  end
endmodule
